// [pcie_port_link_control.sv]
// Link control register of one switch port and its controls to the PHY
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module pcie_port_link_control (
  // Clock and reset
  input  wire logic                            ref_clk_in,
  input  wire logic                            rst_n_in,
  // Register port
  input  wire logic [11:0]                     reg_addr_in,
  input  wire logic [15:0]                     reg_wdata_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  output logic      [15:0]                     reg_rdata_out,
  // Serial configuration load of the power-state field
  input  wire logic                            lpe_load_in,
  input  wire logic [1:0]                      lpe_load_val_in,
  // Port straps (pins)
  input  wire logic                            downstream_in,
  input  wire logic                            bw_notification_capable_in,
  // Training state machine
  input  wire link_control_pkg::phy_status_type phy_status_in,
  output link_control_pkg::phy_ctrl_type       phy_ctrl_out,
  // Interrupt request toward the port's message logic
  output logic                                 bw_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and strap synchronisers
  logic [1:0] rst_sync_q, rst_sync_d;
  logic       rst_n;
  logic [1:0] down_sync_q, down_sync_d;
  logic [1:0] lbn_sync_q, lbn_sync_d;

  // Reset asserts at once but lifts only on a clean edge
  always_comb
  begin
    rst_sync_d = {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= rst_sync_d;
  end
  assign rst_n = rst_sync_q[1];

  // Straps are pins: two stages before any logic reads them
  always_comb
  begin
    down_sync_d = {down_sync_q[0], downstream_in};
    lbn_sync_d  = {lbn_sync_q[0], bw_notification_capable_in};
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      down_sync_q <= 2'h0;
      lbn_sync_q  <= 2'h0;
    end
    else
    begin
      down_sync_q <= down_sync_d;
      lbn_sync_q  <= lbn_sync_d;
    end
  end

  logic is_down;
  logic irq_allowed;
  assign is_down     = down_sync_q[1];
  assign irq_allowed = down_sync_q[1] & lbn_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [1:0]                      lpe_q, lpe_d;
  logic                            link_disable_bit_q, link_disable_bit_d;
  logic                            common_clock_bit_q, common_clock_bit_d;
  logic                            extended_sync_bit_q, extended_sync_bit_d;
  logic                            bwm_ie_q, bwm_ie_d;
  logic                            abw_ie_q, abw_ie_d;
  logic                            bwm_sts_q, bwm_sts_d;
  logic                            abw_sts_q, abw_sts_d;
  logic                            retrain_pend_q, retrain_pend_d;
  link_control_pkg::train_cfg_type applied_q, applied_d;
  logic                            stale_q, stale_d;
  logic                            wr_ctl;
  logic                            wr_sts;
  logic                            in_train;

  assign wr_ctl   = reg_wr_in && (reg_addr_in == link_control_pkg::link_control_off);
  assign wr_sts   = reg_wr_in && (reg_addr_in == link_control_pkg::link_status_off);
  assign in_train = phy_status_in.in_recovery | phy_status_in.in_config;

  always_comb
  begin
    lpe_d          = lpe_q;
    link_disable_bit_d         = link_disable_bit_q;
    common_clock_bit_d         = common_clock_bit_q;
    extended_sync_bit_d        = extended_sync_bit_q;
    bwm_ie_d       = bwm_ie_q & irq_allowed;
    abw_ie_d       = abw_ie_q & irq_allowed;
    retrain_pend_d = retrain_pend_q;
    applied_d      = applied_q;
    stale_d        = stale_q;
    if (lpe_load_in)
      lpe_d = lpe_load_val_in;
    // Retrain may come with other field changes in one write
    if (wr_ctl)
    begin
      lpe_d    = reg_wdata_in[link_control_pkg::lpe_lsb +: 2];
      link_disable_bit_d   = reg_wdata_in[link_control_pkg::link_disable_bit_pos];
      common_clock_bit_d   = reg_wdata_in[link_control_pkg::common_clock_bit_pos];
      extended_sync_bit_d  = reg_wdata_in[link_control_pkg::extended_sync_bit_pos];
      bwm_ie_d = reg_wdata_in[link_control_pkg::bwm_ie_pos] & irq_allowed;
      abw_ie_d = reg_wdata_in[link_control_pkg::abw_ie_pos] & irq_allowed;
      if (reg_wdata_in[link_control_pkg::retrain_pos])
      begin
        retrain_pend_d = 1'b1;
        if (in_train)
          stale_d = 1'b1;
        else
        begin
          applied_d.common_clock  = reg_wdata_in[link_control_pkg::common_clock_bit_pos];
          applied_d.extended_sync = reg_wdata_in[link_control_pkg::extended_sync_bit_pos];
          stale_d = 1'b0;
        end
      end
    end
    // Pending request accepted once PHY reaches Recovery
    if (retrain_pend_q && phy_status_in.in_recovery)
      retrain_pend_d = 1'b0;
    // Deferred changes enter as soon as training ends (neither Recovery nor Configuration)
    if (stale_q && !in_train && !(wr_ctl && reg_wdata_in[link_control_pkg::retrain_pos]))
    begin
      applied_d.common_clock  = common_clock_bit_q;
      applied_d.extended_sync = extended_sync_bit_q;
      stale_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bandwidth status bits
  always_comb
  begin
    bwm_sts_d = bwm_sts_q;
    abw_sts_d = abw_sts_q;
    // Write one to clear; set wins over clear
    if (wr_sts)
    begin
      if (reg_wdata_in[link_control_pkg::bwm_sts_pos])
        bwm_sts_d = 1'b0;
      if (reg_wdata_in[link_control_pkg::abw_sts_pos])
        abw_sts_d = 1'b0;
    end
    if (!phy_status_in.link_down && phy_status_in.retrain_done)
      bwm_sts_d = 1'b1;
    if (!phy_status_in.link_down && phy_status_in.auto_bw_change)
    begin
      bwm_sts_d = 1'b1;
      abw_sts_d = 1'b1;
    end
    // Status hardwired to zero where the capability is absent
    bwm_sts_d = bwm_sts_d & irq_allowed;
    abw_sts_d = abw_sts_d & irq_allowed;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bwm_sts_q <= 1'b0;
      abw_sts_q <= 1'b0;
    end
    else
    begin
      bwm_sts_q <= bwm_sts_d;
      abw_sts_q <= abw_sts_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register fields and retrain bookkeeping
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lpe_q          <= link_control_pkg::lpe_reset;
      link_disable_bit_q         <= 1'b0;
      common_clock_bit_q         <= 1'b0;
      extended_sync_bit_q        <= 1'b0;
      bwm_ie_q       <= 1'b0;
      abw_ie_q       <= 1'b0;
      retrain_pend_q <= 1'b0;
      applied_q      <= '0;
      stale_q        <= 1'b0;
    end
    else
    begin
      lpe_q          <= lpe_d;
      link_disable_bit_q         <= link_disable_bit_d;
      common_clock_bit_q         <= common_clock_bit_d;
      extended_sync_bit_q        <= extended_sync_bit_d;
      bwm_ie_q       <= bwm_ie_d;
      abw_ie_q       <= abw_ie_d;
      retrain_pend_q <= retrain_pend_d;
      applied_q      <= applied_d;
      stale_q        <= stale_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] ctl_view;
  logic [15:0] sts_view;

  always_comb
  begin
    ctl_view = 16'h0000;
    ctl_view[link_control_pkg::lpe_lsb +: 2]      = lpe_q;
    ctl_view[link_control_pkg::rcb_pos]           = 1'b0;
    ctl_view[link_control_pkg::link_disable_bit_pos]          = link_disable_bit_q;
    ctl_view[link_control_pkg::retrain_pos]       = 1'b0;
    ctl_view[link_control_pkg::common_clock_bit_pos]          = common_clock_bit_q;
    ctl_view[link_control_pkg::extended_sync_bit_pos]         = extended_sync_bit_q;
    ctl_view[link_control_pkg::clkpm_pos]         = 1'b0;
    ctl_view[link_control_pkg::awd_pos]           = 1'b0;
    ctl_view[link_control_pkg::bwm_ie_pos]        = bwm_ie_q;
    ctl_view[link_control_pkg::abw_ie_pos]        = abw_ie_q;
  end

  // Training flag only means something on a downstream port
  always_comb
  begin
    sts_view = 16'h0000;
    sts_view[link_control_pkg::ltrain_pos]  = is_down & (in_train | retrain_pend_q);
    sts_view[link_control_pkg::bwm_sts_pos] = bwm_sts_q;
    sts_view[link_control_pkg::abw_sts_pos] = abw_sts_q;
  end

  // Zero outside the strobe cycle, so stale data never shows
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_rd_in)
    begin
      if (reg_addr_in == link_control_pkg::link_control_off)
        rdata_d = ctl_view;
      else if (reg_addr_in == link_control_pkg::link_status_off)
        rdata_d = sts_view;
      else if (reg_addr_in == link_control_pkg::port_config_off)
      begin
        rdata_d[link_control_pkg::cfg_down_pos] = is_down;
        rdata_d[link_control_pkg::cfg_lbn_pos]  = lbn_sync_q[1];
      end
      else
        rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end
  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Controls to the training state machine and the interrupt
  link_control_pkg::phy_ctrl_type ctrl_q, ctrl_d;
  logic                           irq_q, irq_d;

  always_comb
  begin
    // Receiver L0s is always supported; only transmit entry is gated
    ctrl_d.tx_l0s_allowed = lpe_q[0];
    ctrl_d.l1_allowed     = lpe_q[1];
    ctrl_d.link_disable   = link_disable_bit_q & is_down;
    ctrl_d.goto_recovery  = retrain_pend_q & ~phy_status_in.in_recovery;
    ctrl_d.extra_sets     = applied_q.extended_sync;
    // Exit latencies are not derived from this bit
    ctrl_d.common_clock   = applied_q.common_clock;
  end

  // Level, not pulse: stays up until software clears the status or its enable bit
  always_comb
  begin
    irq_d = (bwm_ie_q & bwm_sts_q) | (abw_ie_q & abw_sts_q);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= '0;
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end
  assign phy_ctrl_out = ctrl_q;
  assign bw_irq_out   = irq_q;

endmodule : pcie_port_link_control

// [link_control_pkg.sv]
// Package: offsets, field positions, reset values and types of the link control block
package link_control_pkg;

  // Register map (byte offsets on the plain register port)
  localparam logic [11:0] link_control_off     = 12'h050;
  localparam logic [11:0] link_status_off      = 12'h052;
  localparam logic [11:0] port_config_off      = 12'h060;

  // Link control field positions
  localparam int lpe_lsb        = 0;
  localparam int rcb_pos        = 3;
  localparam int link_disable_bit_pos       = 4;
  localparam int retrain_pos    = 5;
  localparam int common_clock_bit_pos       = 6;
  localparam int extended_sync_bit_pos      = 7;
  localparam int clkpm_pos      = 8;
  localparam int awd_pos        = 9;
  localparam int bwm_ie_pos     = 10;
  localparam int abw_ie_pos     = 11;

  // Link status field positions
  localparam int ltrain_pos     = 11;
  localparam int bwm_sts_pos    = 14;
  localparam int abw_sts_pos    = 15;

  // Port config field positions (own register)
  localparam int cfg_down_pos   = 0;
  localparam int cfg_lbn_pos    = 1;

  // Reset values
  localparam logic [1:0] lpe_reset = 2'h0;

  // Low-power entry encodings
  localparam logic [1:0] lpe_disabled = 2'h0;
  localparam logic [1:0] lpe_l0s      = 2'h1;
  localparam logic [1:0] lpe_l1       = 2'h2;
  localparam logic [1:0] lpe_both     = 2'h3;

  // Fields that affect training and are applied at a training boundary
  typedef struct packed {
    logic       common_clock;
    logic       extended_sync;
  } train_cfg_type;

  // Status arriving from the training state machine
  typedef struct packed {
    logic       in_recovery;
    logic       in_config;
    logic       link_down;
    logic       retrain_done;
    logic       auto_bw_change;
  } phy_status_type;

  // Controls going to the training state machine
  typedef struct packed {
    logic       tx_l0s_allowed;
    logic       l1_allowed;
    logic       link_disable;
    logic       goto_recovery;
    logic       extra_sets;
    logic       common_clock;
  } phy_ctrl_type;

endpackage : link_control_pkg

// [link_control_sva.sv]
// Checker: port-level assertions of the link control block
`timescale 1ns/10ps
module link_control_sva (
  // Clock, reset, register port
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // Load, straps, PHY, interrupt
  input wire logic        lpe_load_in,
  input wire logic [1:0]  lpe_load_val_in,
  input wire logic        downstream_in,
  input wire logic        bw_notification_capable_in,
  input wire link_control_pkg::phy_status_type phy_status_in,
  input wire link_control_pkg::phy_ctrl_type   phy_ctrl_out,
  input wire logic        bw_irq_out
);
  logic ctl_wr;
  logic ctl_rd;
  logic training;
  assign ctl_wr = reg_wr_in && reg_addr_in == 12'h050;
  assign ctl_rd = reg_rd_in && reg_addr_in == 12'h050;
  assign training = phy_status_in.in_recovery || phy_status_in.in_config;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  chk_ctrl_fixed: assert property ($past(ctl_rd) |->
    (reg_rdata_out & 16'hF32C) == 16'h0000) else $error("fixed bits set");
  chk_retrain_go: assert property (ctl_wr && reg_wdata_in[5]
    && !phy_status_in.in_recovery |-> ##2 phy_ctrl_out.goto_recovery)
    else $error("retrain not issued");
  chk_goto_hold: assert property (phy_ctrl_out.goto_recovery
    && !phy_status_in.in_recovery |=> phy_ctrl_out.goto_recovery)
    else $error("retrain request dropped early");
  chk_goto_drop: assert property (phy_ctrl_out.goto_recovery
    && phy_status_in.in_recovery |-> ##2 !phy_ctrl_out.goto_recovery)
    else $error("retrain request not released");
  // Write reaches the PHY controls two cycles later, so no write in between
  chk_lpe_map: assert property ($past(ctl_wr && !lpe_load_in, 2)
    && !$past(reg_wr_in) && !$past(lpe_load_in) |->
    {phy_ctrl_out.l1_allowed, phy_ctrl_out.tx_l0s_allowed}
    == $past(reg_wdata_in[1:0], 2)) else $error("power entry mismatch");
  chk_link_disable_bit_up: assert property (!downstream_in
    && !$past(downstream_in, 6) |-> !phy_ctrl_out.link_disable)
    else $error("link disabled on upstream port");
  chk_irq_up: assert property (!downstream_in
    && !$past(downstream_in, 6) |-> !bw_irq_out)
    else $error("interrupt on upstream port");
  chk_train_stable: assert property (training && $past(training) |->
    $stable({phy_ctrl_out.common_clock, phy_ctrl_out.extra_sets}))
    else $error("training fields changed in training");
  cover property (phy_ctrl_out.goto_recovery && training);
  cover property ($rose(bw_irq_out));
  cover property (phy_ctrl_out.link_disable);
endmodule : link_control_sva
bind pcie_port_link_control link_control_sva chk_i (
  .ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .lpe_load_in, .lpe_load_val_in,
  .downstream_in, .bw_notification_capable_in, .phy_status_in,
  .phy_ctrl_out, .bw_irq_out);

// [phy_model.sv]
// Partner model: training state machine beyond the port
`timescale 1ns/10ps
module phy_model #(
  parameter int delay = 4
) (
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           hold_cfg_in,
  input  wire logic                           auto_bw_in,
  input  wire link_control_pkg::phy_ctrl_type ctrl_in,
  output link_control_pkg::phy_status_type    status_out
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != 4'h0)
      cnt_d = (cnt_q == 4'(delay + 4)) ? 4'h0 : cnt_q + 4'h1;
    else if (ctrl_in.goto_recovery)
      cnt_d = 4'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  // Slow entry so the request must be held; exit without link-down
  always_comb
  begin
    status_out = '0;
    status_out.in_recovery = cnt_q >= 4'(delay) && cnt_q < 4'(delay + 4);
    status_out.in_config = hold_cfg_in;
    status_out.retrain_done = cnt_q == 4'(delay + 4);
    status_out.auto_bw_change = auto_bw_in;
  end
endmodule : phy_model

// [tb_top.sv]
// Testbench: register-level tests of the link control block
`timescale 1ns/10ps
module tb_top;
  localparam logic [11:0] ctl = 12'h050;
  localparam logic [11:0] sts = 12'h052;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        lpe_load_in = 1'b0;
  logic [1:0]  lpe_load_val_in = 2'h0;
  logic        downstream_in = 1'b1;
  logic        bw_notification_capable_in = 1'b1;
  logic        hold_cfg = 1'b0;
  logic        auto_bw = 1'b0;
  logic [15:0] reg_rdata_out;
  logic        bw_irq_out;
  logic [15:0] rv;
  int          err_count = 0;
  int          check_count = 0;
  link_control_pkg::phy_status_type phy_status_in;
  link_control_pkg::phy_ctrl_type   phy_ctrl_out;
  always #2 ref_clk_in = ~ref_clk_in;
  pcie_port_link_control DUT (.ref_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .lpe_load_in,
    .lpe_load_val_in, .downstream_in, .bw_notification_capable_in,
    .phy_status_in, .phy_ctrl_out, .bw_irq_out);
  phy_model far_end (.clk_in(ref_clk_in), .rst_n_in, .hold_cfg_in(hold_cfg),
    .auto_bw_in(auto_bw), .ctrl_in(phy_ctrl_out), .status_out(phy_status_in));
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // Read data stand one cycle only, so sample just after that edge
  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [15:0] m, e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    rv = reg_rdata_out & m;
    chk(n, rv, e);
  endtask : rdc
  task automatic wait_go;
    for (int i = 0; i < 20; i++)
      if (phy_ctrl_out.goto_recovery !== 1'b1)
        tick(1);
    chk("goto", phy_ctrl_out.goto_recovery, 16'h0001);
  endtask : wait_go
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    tick(6);
    rdc("ctl_reset", ctl, 16'hFFFF, 16'h0000);
    rdc("unmapped", 12'h070, 16'hFFFF, 16'h0000);
    for (int v = 0; v < 4; v++)
    begin
      wr(ctl, 16'(v));
      rdc("lpe", ctl, 16'hFFFF, 16'(v));
      chk("l0s_tx", phy_ctrl_out.tx_l0s_allowed, 16'(v % 2));
      chk("l1", phy_ctrl_out.l1_allowed, 16'(v / 2));
    end
    @(posedge ref_clk_in);
    lpe_load_in <= 1'b1;
    lpe_load_val_in <= 2'h2;
    @(posedge ref_clk_in);
    lpe_load_in <= 1'b0;
    rdc("lpe_load", ctl, 16'h0003, 16'h0002);
    $display("test power_entry done");
    wr(ctl, 16'hFFFF);
    rdc("ctl_view", ctl, 16'hFFFF, 16'h0CD3);
    chk("link_disable_bit", phy_ctrl_out.link_disable, 16'h0001);
    chk("extended_sync_bit", phy_ctrl_out.extra_sets, 16'h0001);
    wait_go;
    tick(16);
    wr(ctl, 16'h0000);
    wr(sts, 16'hC000);
    $display("test all_fields done");
    wr(ctl, 16'h0440);
    wr(ctl, 16'h0460);
    wait_go;
    chk("common_clock_bit_now", phy_ctrl_out.common_clock, 16'h0001);
    tick(16);
    rdc("bwm_sts", sts, 16'hC000, 16'h4000);
    chk("bwm_irq", bw_irq_out, 16'h0001);
    wr(sts, 16'hC000);
    tick(2);
    chk("irq_clr", bw_irq_out, 16'h0000);
    $display("test retrain done");
    @(posedge ref_clk_in);
    hold_cfg <= 1'b1;
    wr(ctl, 16'h00A0);
    wait_go;
    chk("extended_sync_bit_held", phy_ctrl_out.extra_sets, 16'h0000);
    tick(12);
    @(posedge ref_clk_in);
    hold_cfg <= 1'b0;
    tick(4);
    chk("extended_sync_bit_late", phy_ctrl_out.extra_sets, 16'h0001);
    $display("test in_training done");
    wr(sts, 16'hC000);
    wr(ctl, 16'h0800);
    @(posedge ref_clk_in);
    auto_bw <= 1'b1;
    @(posedge ref_clk_in);
    auto_bw <= 1'b0;
    tick(3);
    chk("abw_irq", bw_irq_out, 16'h0001);
    rdc("abw_sts", sts, 16'hC000, 16'hC000);
    wr(ctl, 16'h0000);
    $display("test autonomous done");
    downstream_in <= 1'b0;
    tick(6);
    wr(ctl, 16'h0C10);
    rdc("up_ie", ctl, 16'hFFFF, 16'h0010);
    chk("up_link_disable_bit", phy_ctrl_out.link_disable, 16'h0000);
    @(posedge ref_clk_in);
    downstream_in <= 1'b1;
    bw_notification_capable_in <= 1'b0;
    tick(6);
    wr(ctl, 16'h0C00);
    rdc("nocap_ie", ctl, 16'hFFFF, 16'h0000);
    $display("test straps done");
    end_sim;
  end
  // About 140 cycles expected; generous margin before giving up
  initial
  begin
    #20000;
    err_count++;
    end_sim;
  end
endmodule : tb_top
